/* rtl/spr_pkg.sv */
// Shared constants and types of the flash pin role select block.
package spr_pkg;
  // ----------------------------------------
  // Pin and data geometry
  // ----------------------------------------
  localparam int LANES = 4;
  localparam int BYTE_BITS = 8;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int MCLK_PERIOD_NS = 25;
  localparam int RESET_PULSE_NS = 100;
  // A least time, so it rounds up, never below one cycle.
  localparam int RESET_PULSE_CYCLES_RAW = (RESET_PULSE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_CYCLES_RAW < 1) ? 1 : RESET_PULSE_CYCLES_RAW;
  localparam int RESET_COUNT_BITS = 8;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] LANE_OE_RESET = 4'h0;
  localparam logic [7:0] RX_BYTE_RESET = 8'h00;
  // ----------------------------------------
  // Transfer width of the current command phase
  // ----------------------------------------
  typedef enum logic [1:0] {SPR_SINGLE, SPR_DUAL, SPR_QUAD} spr_width_t;
endpackage

/* rtl/spr_lane_if.sv */
// Carrier between the core-clock side and the serial-clock side of the pin mux.
`timescale 1ns/1ps
interface spr_lane_if;
  // Core side to link side, quasi-static while chip-select is low.
  logic [1:0] width;
  logic driveOut;
  logic [7:0] txData;
  // Link side to core side.
  logic [7:0] rxHold;
  logic rxToggle;
  logic [3:0] laneOut;
  logic [3:0] laneOe;
  modport core (output width, output driveOut, output txData, input rxHold, input rxToggle, input laneOut,
    input laneOe);
  modport link (input width, input driveOut, input txData, output rxHold, output rxToggle, output laneOut,
    output laneOe);
endinterface

/* rtl/spr_link.sv */
// Serial-clock side: lane capture on rising edges and lane drive on falling edges.
`timescale 1ns/1ps
module spr_link (
  // Clock and resets
  input wire logic sck,
  input wire logic reset_n,
  input wire logic frameRst_n,
  // Raw lane inputs
  input wire logic [3:0] laneIn,
  // Core carrier
  spr_lane_if.link lk
);
  logic [1:0] widthMeta;
  logic [1:0] widthSync;
  logic driveMeta;
  logic driveSync;
  logic [7:0] shiftIn;
  logic [2:0] bitCount;
  logic [2:0] outIdx;
  logic [7:0] next_shift;
  logic [2:0] step;

  // ----------------------------------------
  // Width crossing; the config must settle before the frame opens.
  // ----------------------------------------
  always_ff @(posedge sck or negedge frameRst_n) begin
    if (!frameRst_n) begin
      widthMeta <= 2'h0;
      widthSync <= 2'h0;
      driveMeta <= 1'b0;
      driveSync <= 1'b0;
    end else begin
      widthMeta <= lk.width;
      widthSync <= widthMeta;
      driveMeta <= lk.driveOut;
      driveSync <= driveMeta;
    end
  end

  always_comb begin
    step = 3'h1;
    next_shift = {shiftIn[6:0], laneIn[0]};
    if (spr_pkg::spr_width_t'(widthSync) == spr_pkg::SPR_DUAL) begin
      step = 3'h2;
      next_shift = {shiftIn[5:0], laneIn[1:0]};
    end else if (spr_pkg::spr_width_t'(widthSync) == spr_pkg::SPR_QUAD) begin
      step = 3'h4;
      next_shift = {shiftIn[3:0], laneIn[3:0]};
    end
  end

  // ----------------------------------------
  // Capture; frame state clears while chip-select is high.
  // ----------------------------------------
  always_ff @(posedge sck or negedge frameRst_n) begin
    if (!frameRst_n) begin
      shiftIn <= spr_pkg::RX_BYTE_RESET;
      bitCount <= 3'h0;
    end else begin
      shiftIn <= next_shift; // [R10]
      bitCount <= bitCount + step;
    end
  end

  // The toggle must survive frame ends, else the core would see a false event.
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      lk.rxHold <= spr_pkg::RX_BYTE_RESET;
      lk.rxToggle <= 1'b0;
    end else if (frameRst_n && (3'(bitCount + step) == 3'h0)) begin
      lk.rxHold <= next_shift;
      lk.rxToggle <= ~lk.rxToggle;
    end
  end

  // ----------------------------------------
  // Drive after falling edges.
  // ----------------------------------------
  always_ff @(negedge sck or negedge frameRst_n) begin
    if (!frameRst_n) begin
      outIdx <= 3'h0;
      lk.laneOut <= 4'h0;
      lk.laneOe <= spr_pkg::LANE_OE_RESET;
    end else begin
      unique case (spr_pkg::spr_width_t'(widthSync))
        spr_pkg::SPR_SINGLE: begin
          lk.laneOut <= {2'b00, lk.txData[3'h7 - outIdx], 1'b0};
          lk.laneOe <= driveSync ? 4'h2 : 4'h0; // [R2] [R3] [R10]
          outIdx <= outIdx + 3'h1;
        end
        spr_pkg::SPR_DUAL: begin
          lk.laneOut <= {2'b00, lk.txData[3'h7 - outIdx], lk.txData[3'h6 - outIdx]};
          lk.laneOe <= driveSync ? 4'h3 : 4'h0; // [R2] [R3]
          outIdx <= outIdx + 3'h2;
        end
        default: begin
          lk.laneOut <= outIdx[2] ? lk.txData[3:0] : lk.txData[7:4];
          lk.laneOe <= driveSync ? 4'hf : 4'h0;
          outIdx <= outIdx + 3'h4;
        end
      endcase
    end
  end
endmodule

/* rtl/spr_pin_role_select.sv */
// Pin role selection for the shared lanes of a serial multi-lane flash device.
// Behaviour
// R1: Dedicated reset low returns device to standby.
// R2: Lane zero: serial input, or bidirectional lane.
// R3: Lane one: serial output, or bidirectional lane.
// R4: Lane two guards writes when quad off, locked.
// R5: Quad enable makes lane two data, no guard.
// R6: Host drives guard level during register writes.
// R7: Lane three carries data in quad modes.
// R8: Lane three resets only when enabled and idle.
// R9: Test function inactive while its pin low.
// R10: Capture on rising, drive after falling edges.
// R11: Chip-select high: ignore inputs, release outputs.
// R12: Shared reset needs full pulse with deselect.
// R13: Guarded register writes dropped silently, no error.
// R14: Data lane roles outrank the write guard.
`timescale 1ns/1ps
module spr_pin_role_select #(
  parameter int RESET_PULSE_CYCLES = spr_pkg::RESET_PULSE_CYCLES
) (
  // Clocks and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sck,
  // Device pins
  input wire logic csPin_n,
  input wire logic hwResetPin_n,
  input wire logic doNotUsePin,
  input wire logic [3:0] laneIn,
  output logic [3:0] laneOut,
  output logic [3:0] laneOe,
  // Configuration bits
  input wire logic quadEnableBit,
  input wire logic statusLockNvBit,
  input wire logic quadCommandModeBit,
  input wire logic sharedResetEnableBit,
  input wire logic statusProtectBit,
  // Command side
  input wire logic [1:0] cmdWidth,
  input wire logic driveOut,
  input wire logic [7:0] txData,
  input wire logic regWriteCmd,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic regWriteCommit,
  output logic regWriteDropped,
  // Role and reset status
  output logic lane2IsGuard,
  output logic lane2IsData,
  output logic lane3IsData,
  output logic lane3IsReset,
  output logic guardLow,
  output logic testFunctionActive,
  output logic deviceReset,
  output logic standbyEntered
);
  localparam int SYNC_N = 6;
  localparam logic [spr_pkg::RESET_COUNT_BITS-1:0] PULSE_LAST =
    spr_pkg::RESET_COUNT_BITS'(RESET_PULSE_CYCLES - 1);

  spr_lane_if lane ();

  logic [SYNC_N-1:0] syncIn;
  logic [SYNC_N-1:0] syncMeta;
  logic [SYNC_N-1:0] syncOut;
  logic csSync_n;
  logic hwResetSync_n;
  logic lane2Sync;
  logic lane3Sync;
  logic toggleSeen;
  logic frameRst_n;
  logic quadOn;
  logic csLowPrev;
  logic guardSeenLow;
  logic [spr_pkg::RESET_COUNT_BITS-1:0] pinCount;
  logic [spr_pkg::RESET_COUNT_BITS-1:0] sharedCount;
  logic pinPulse;
  logic sharedPulse;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  assign syncIn = {lane.rxToggle, laneIn[3], laneIn[2], doNotUsePin, hwResetPin_n, csPin_n};

  generate
    for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          // Pins start at their idle pull levels, so no false low or reset follows a reset.
          syncMeta[i] <= (i == 2 || i == 5) ? 1'b0 : 1'b1;
          syncOut[i] <= (i == 2 || i == 5) ? 1'b0 : 1'b1;
        end else begin
          syncMeta[i] <= syncIn[i];
          syncOut[i] <= syncMeta[i];
        end
      end
    end
  endgenerate

  assign csSync_n = syncOut[0];
  assign hwResetSync_n = syncOut[1];
  assign lane2Sync = syncOut[3];
  assign lane3Sync = syncOut[4];

  // ----------------------------------------
  // Role decode
  // ----------------------------------------
  assign quadOn = quadEnableBit | quadCommandModeBit;

  always_comb begin
    lane2IsData = quadOn; // [R5] [R14]
    lane2IsGuard = ~quadOn & statusLockNvBit; // [R4] [R14]
    lane3IsData = quadEnableBit | (quadCommandModeBit & ~csPin_n); // [R7]
    lane3IsReset = sharedResetEnableBit & (~quadOn | csPin_n); // [R8]
  end

  assign testFunctionActive = syncOut[2]; // [R9]
  assign guardLow = lane2IsGuard & ~lane2Sync; // [R4]

  // ----------------------------------------
  // Lane drive; chip-select high releases every lane at once.
  // ----------------------------------------
  assign lane.width = deviceReset ? 2'(spr_pkg::SPR_SINGLE) : cmdWidth;
  assign lane.driveOut = driveOut;
  assign lane.txData = txData;
  assign frameRst_n = reset_n & ~csPin_n & ~deviceReset; // [R11]

  always_comb begin
    laneOut = lane.laneOut;
    laneOe = lane.laneOe & {lane3IsData, lane2IsData, 2'b11}; // [R2] [R3] [R14]
    if (csPin_n) begin
      laneOe = spr_pkg::LANE_OE_RESET; // [R11]
    end
  end

  spr_link u_link (
    .sck(sck),
    .reset_n(reset_n),
    .frameRst_n(frameRst_n),
    .laneIn(laneIn),
    .lk(lane.link)
  );

  // ----------------------------------------
  // Received bytes
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      toggleSeen <= 1'b0;
      rxValid <= 1'b0;
      rxData <= spr_pkg::RX_BYTE_RESET;
    end else begin
      toggleSeen <= syncOut[5];
      rxValid <= (syncOut[5] != toggleSeen) && !deviceReset;
      if (syncOut[5] != toggleSeen) begin
        // The held byte is stable for the whole crossing, so it is read as a word.
        rxData <= lane.rxHold;
      end
    end
  end

  // ----------------------------------------
  // Register-write guard, judged at frame end
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      csLowPrev <= 1'b0;
      guardSeenLow <= 1'b0;
      regWriteCommit <= 1'b0;
      regWriteDropped <= 1'b0;
    end else begin
      csLowPrev <= ~csSync_n;
      regWriteCommit <= 1'b0;
      regWriteDropped <= 1'b0;
      if (!csSync_n && !csLowPrev) begin
        // A low already present in the opening cycle counts for the new frame.
        guardSeenLow <= guardLow;
      end else if (!csSync_n && guardLow) begin
        // The host holds the guard level for the whole command, so any low counts.
        guardSeenLow <= 1'b1; // [R6]
      end
      if (csSync_n && csLowPrev && regWriteCmd && !deviceReset) begin
        if (guardSeenLow && statusProtectBit) begin
          regWriteDropped <= 1'b1; // [R13]
        end else begin
          regWriteCommit <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Reset pulse timers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pinCount <= '0;
      pinPulse <= 1'b0;
    end else if (hwResetSync_n) begin
      pinCount <= '0;
      pinPulse <= 1'b0;
    end else if (pinCount == PULSE_LAST) begin
      pinPulse <= 1'b1; // [R1]
    end else begin
      pinCount <= pinCount + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sharedCount <= '0;
      sharedPulse <= 1'b0;
    end else if (!(lane3IsReset && csSync_n && !lane3Sync)) begin
      sharedCount <= '0; // [R12]
      sharedPulse <= 1'b0;
    end else if (sharedCount == PULSE_LAST) begin
      sharedPulse <= 1'b1; // [R12]
    end else begin
      sharedCount <= sharedCount + 1'b1;
    end
  end

  // ----------------------------------------
  // Standby return
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      deviceReset <= 1'b0;
      standbyEntered <= 1'b0;
    end else begin
      deviceReset <= pinPulse | sharedPulse; // [R1] [R12]
      standbyEntered <= deviceReset & ~(pinPulse | sharedPulse); // [R1]
    end
  end
endmodule

/* tb/spr_pin_role_select_sva.sv */
// Assertion checker on the ports of the pin role select block.
`timescale 1ns/1ps
module spr_pin_role_select_sva #(
  parameter int RESET_PULSE_CYCLES = 4
) (
  // Clock, reset and pins
  input wire logic mclk, reset_n, csPin_n, hwResetPin_n, doNotUsePin,
  input wire logic [3:0] laneOe,
  input wire logic [1:0] cmdWidth,
  // Configuration bits
  input wire logic quadEnableBit, statusLockNvBit, quadCommandModeBit, sharedResetEnableBit, statusProtectBit,
  // Status outputs
  input wire logic regWriteCommit, regWriteDropped, lane2IsGuard, lane2IsData, lane3IsData, lane3IsReset,
  input wire logic testFunctionActive, deviceReset, standbyEntered
);
  wire quadOn = quadEnableBit || quadCommandModeBit;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_idle; csPin_n |-> laneOe == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("lanes driven while deselected");
  property p_l2data; quadOn |-> lane2IsData && !lane2IsGuard; endproperty
  a_l2data: assert property (p_l2data) else $error("lane two not data in quad");
  property p_guard; !quadOn && statusLockNvBit |-> lane2IsGuard && !laneOe[2]; endproperty
  a_guard: assert property (p_guard) else $error("lane two not guard");
  property p_l3data; !csPin_n && quadOn |-> lane3IsData && !lane3IsReset; endproperty
  a_l3data: assert property (p_l3data) else $error("lane three not data");
  property p_l3rst; lane3IsReset == (sharedResetEnableBit && (csPin_n || !quadOn)); endproperty
  a_l3rst: assert property (p_l3rst) else $error("lane three reset role wrong");
  property p_single; !csPin_n && cmdWidth == 2'h0 |-> !laneOe[0]; endproperty
  a_single: assert property (p_single) else $error("lane zero driven in single width");
  property p_dnu; !doNotUsePin [*4] |-> !testFunctionActive; endproperty
  a_dnu: assert property (p_dnu) else $error("test function active with pin low");
  property p_hwrst; !hwResetPin_n [*8] |-> deviceReset; endproperty
  a_hwrst: assert property (p_hwrst) else $error("reset pin low but no reset");
  property p_stby; $fell(deviceReset) |-> ##[0:1] standbyEntered; endproperty
  a_stby: assert property (p_stby) else $error("no standby after reset");
  property p_drop; regWriteDropped |-> statusProtectBit && !regWriteCommit; endproperty
  a_drop: assert property (p_drop) else $error("write dropped without protection");
endmodule
bind spr_pin_role_select spr_pin_role_select_sva #(.RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) u_spr_pin_role_select_sva (
  .mclk, .reset_n, .csPin_n, .hwResetPin_n, .doNotUsePin, .laneOe, .cmdWidth, .quadEnableBit, .statusLockNvBit,
  .quadCommandModeBit, .sharedResetEnableBit, .statusProtectBit, .regWriteCommit, .regWriteDropped, .lane2IsGuard,
  .lane2IsData, .lane3IsData, .lane3IsReset, .testFunctionActive, .deviceReset, .standbyEntered);

/* tb/spr_host_model.sv */
// Behavioural host controller that drives the serial lanes of the device.
`timescale 1ns/1ps
module spr_host_model (
  // Host to device
  output logic sck,
  output logic csPin_n,
  output logic [3:0] laneIn,
  // Device to host
  input wire logic [3:0] laneOut,
  input wire logic [3:0] laneOe
);
  logic [3:0] hostVal = 4'h0, hostEn = 4'h0, lastOe = 4'h0;
  logic guard = 1'b1;
  logic [15:0] outSeen = 16'h0000;
  initial begin
    sck = 1'b0;
    csPin_n = 1'b1;
  end
  // Lanes two and three have pull-ups; undriven lanes zero and one show the inverse of their last level.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      laneIn[i] = laneOe[i] ? laneOut[i] : hostEn[i] ? hostVal[i] : (i > 1) ? 1'b1 : ~hostVal[i];
    end
  end
  task automatic xfer(input int w, input logic [15:0] s);
    int n, st;
    n = 0;
    hostEn = 4'hf;
    #13 csPin_n = 1'b0;
    while (n < 16) begin
      st = (n < 2) ? 1 : w;
      hostVal = 4'(s >> (16 - st));
      if (st < 4) hostVal[3:2] = {1'b1, guard};
      s = s << st;
      #80 sck = 1'b1;
      lastOe = laneOe;
      outSeen = {outSeen[14:0], laneOut[1]};
      #80 sck = 1'b0;
      n += st;
    end
    hostVal[3] = 1'b1;
    #40 csPin_n = 1'b1;
    #40 hostEn = 4'h0;
  endtask
  task automatic pull3(input int ns);
    // Pin edges stay off the core clock edges, so the sampled pulse length is fixed.
    #3;
    hostVal = 4'h0;
    hostEn = 4'h8;
    #(ns) hostVal = 4'hf;
    #10 hostEn = 4'h0;
  endtask
endmodule

/* tb/spr_pin_role_select_test.sv */
// Self-checking bench of the flash pin role select block.
`timescale 1ns/1ps
module spr_pin_role_select_test;
  logic mclk = 1'b0, reset_n = 1'b0, hwResetPin_n = 1'b1, doNotUsePin = 1'b0, driveOut = 1'b0;
  logic quadEnableBit = 1'b0, statusLockNvBit = 1'b0, quadCommandModeBit = 1'b0, sharedResetEnableBit = 1'b0;
  logic statusProtectBit = 1'b0, regWriteCmd = 1'b0;
  logic [1:0] cmdWidth = 2'h0;
  logic [7:0] txData = 8'h5a;
  logic sck, csPin_n, rxValid, regWriteCommit, regWriteDropped, lane2IsGuard, lane2IsData, lane3IsData;
  logic lane3IsReset, guardLow, testFunctionActive, deviceReset, standbyEntered;
  logic [3:0] laneIn, laneOut, laneOe;
  logic [7:0] rxData;
  logic [7:0] rxq[$];
  int fail_count = 0, compares = 0, cyc = 0, nDrop = 0, nCommit = 0, nRst = 0, nStby = 0, nGuard = 0;
  // Rows hold quad, lock, command mode, shared reset, then guard, lane two data, lane three reset.
  logic [6:0] rows [6] = '{7'h24, 7'h2d, 7'h62, 7'h32, 7'h5b, 7'h00};
  logic [3:0] expOe [3] = '{4'h2, 4'h3, 4'hf};
  always #12.5 mclk = ~mclk;
  spr_pin_role_select #(.RESET_PULSE_CYCLES(2)) u_spr_pin_role_select (.mclk, .reset_n, .sck, .csPin_n,
    .hwResetPin_n, .doNotUsePin, .laneIn, .laneOut, .laneOe, .quadEnableBit, .statusLockNvBit,
    .quadCommandModeBit, .sharedResetEnableBit, .statusProtectBit, .cmdWidth, .driveOut, .txData, .regWriteCmd,
    .rxData, .rxValid, .regWriteCommit, .regWriteDropped, .lane2IsGuard, .lane2IsData, .lane3IsData,
    .lane3IsReset, .guardLow, .testFunctionActive, .deviceReset, .standbyEntered);
  spr_host_model u_spr_host_model (.sck, .csPin_n, .laneIn, .laneOut, .laneOe);
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic setCfg(input logic [3:0] b);
    @(posedge mclk);
    {quadEnableBit, statusLockNvBit, quadCommandModeBit, sharedResetEnableBit} <= b;
  endtask
  task automatic frame(input int w, input logic [15:0] s);
    u_spr_host_model.xfer(w, s);
    repeat (12) @(posedge mclk);
  endtask
  // The ceiling sits well above the roughly nine hundred cycles the scenarios need.
  always @(posedge mclk) begin
    cyc++;
    if (rxValid === 1'b1) rxq.push_back(rxData);
    if (regWriteDropped === 1'b1) nDrop++;
    if (guardLow === 1'b1) nGuard++;
    if (regWriteCommit === 1'b1) nCommit++;
    if (deviceReset === 1'b1) nRst++;
    if (standbyEntered === 1'b1) nStby++;
    if (cyc == 8000) begin
      fail_count++;
      summarize();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (rows[i]) begin
      setCfg(rows[i][6:3]);
      repeat (2) @(posedge mclk);
      chk("roles", {5'h00, lane2IsGuard, lane2IsData, lane3IsReset}, {5'h00, rows[i][2:0]});
    end
    for (int k = 0; k < 3; k++) begin
      setCfg({k == 2, 3'b001});
      cmdWidth <= 2'(k);
      driveOut <= 1'b0;
      rxq.delete();
      frame(1 << k, {8'h96 + 8'(k), 8'h3c});
      if (k < 2) begin
        chk("first byte", rxq[0], 8'h96 + 8'(k));
        chk("second byte", rxq[1], 8'h3c);
      end
      @(posedge mclk);
      driveOut <= 1'b1;
      frame(1 << k, 16'h0f0f);
      chk("lane enables", {4'h0, u_spr_host_model.lastOe}, {4'h0, expOe[k]});
      if (k == 0) chk("serial out", u_spr_host_model.outSeen[14:7], txData);
    end
    chk("reset in quad frame", 8'(nRst), 8'h00);
    setCfg(4'h4);
    driveOut <= 1'b0;
    cmdWidth <= 2'h0;
    regWriteCmd <= 1'b1;
    statusProtectBit <= 1'b1;
    for (int g = 0; g < 2; g++) begin
      u_spr_host_model.guard = g[0];
      frame(1, 16'h0102);
    end
    chk("dropped writes", 8'(nDrop), 8'h01);
    chk("committed writes", 8'(nCommit), 8'h01);
    chk("guard level seen", {7'h00, nGuard > 0}, 8'h01);
    for (int d = 1; d >= 0; d--) begin
      @(posedge mclk);
      doNotUsePin <= d[0];
      repeat (6) @(posedge mclk);
      chk("test function", {7'h00, testFunctionActive}, {7'h00, d[0]});
    end
    setCfg(4'h1);
    regWriteCmd <= 1'b0;
    u_spr_host_model.pull3(25);
    repeat (10) @(posedge mclk);
    chk("short pulse", 8'(nStby), 8'h00);
    u_spr_host_model.pull3(600);
    repeat (10) @(posedge mclk);
    hwResetPin_n <= 1'b0;
    repeat (12) @(posedge mclk);
    hwResetPin_n <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("standby entries", 8'(nStby), 8'h02);
    summarize();
  end
endmodule
